// *** src/daio_top.sv ***
// Dispense automation interface: controller pins in, job status out.
// Assumes controller pins are asynchronous, system status inputs are on CLK,
// and software reaches the registers over AXI4-Lite.
//
// Operation
// - Busy flag low at reset, high during restart
// - Busy flag also high through whole purge
// - Report pressure unit as 0/1/2 code
// - Present eight-bit system error number
// - Latch eight-bit style at job start
// - Strobe rising edge starts a new job
// - Job-done rising edge ends the job
// - Four valve outputs follow their input bits
// - Scale twelve-bit command into flow or pressure
// - End-job-on-fault: cancel job, else clear errors
// - Without end-job-on-fault, always clear errors
// - Remote start when not ready starts restart
// - Remote start when ready starts a purge
// - Swirl motors follow their enable bits
// - Swirl code maps linearly to 6600-24000 rpm
// - Precharge bits apply in gateway mode only
// - Ready means active and no plate alarm
// - Job-active flag from strobe start to end
`timescale 1ns/10ps

module daio_top #(
    parameter int VALVES = 4,
    parameter int SWIRLS = 4
) (
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 SRST,
    // Controller pins
    input  wire daio_pkg::daio_pins_type PINS,
    // System status, same clock
    input  wire logic                 SYS_ACTIVE,
    input  wire logic                 PLATE_ALARM,
    // Controller status outputs
    output logic                      START_PURGE_BUSY,
    output logic [1:0]                PRESSURE_UNITS,
    output logic [7:0]                ERROR_NUM,
    // Actuator outputs
    output logic [3:0]                VALVE_OPEN,
    output logic [3:0]                PRECHARGE_EN,
    output logic [3:0]                SWIRL_RUN,
    output logic [15:0]               CMD_SCALED,
    output logic                      CMD_IS_FLOW,
    output logic [15:0]               SWIRL_RPM,
    // Job and sequence status
    output logic                      JOB_ACTIVE,
    output logic [7:0]                JOB_STYLE,
    output logic                      DISPENSE_READY,
    output logic                      RESTART_REQ,
    output logic                      PURGE_RUN,
    output logic                      ERROR_RESET,
    output logic                      IRQ,
    // AXI4-Lite slave
    input  wire logic [7:0]           S_AXI_AWADDR,
    input  wire logic                 S_AXI_AWVALID,
    output logic                      S_AXI_AWREADY,
    input  wire logic [31:0]          S_AXI_WDATA,
    input  wire logic [3:0]           S_AXI_WSTRB,
    input  wire logic                 S_AXI_WVALID,
    output logic                      S_AXI_WREADY,
    output logic [1:0]                S_AXI_BRESP,
    output logic                      S_AXI_BVALID,
    input  wire logic                 S_AXI_BREADY,
    input  wire logic [7:0]           S_AXI_ARADDR,
    input  wire logic                 S_AXI_ARVALID,
    output logic                      S_AXI_ARREADY,
    output logic [31:0]               S_AXI_RDATA,
    output logic [1:0]                S_AXI_RRESP,
    output logic                      S_AXI_RVALID,
    input  wire logic                 S_AXI_RREADY
);

    ////////////////////////////////////////////////////////////////////////////
    // The pin bundle has fixed four-wide groups
    initial begin
        if (VALVES != 4 || SWIRLS != 4) begin
            $error("daio_top: pin bundle serves exactly four valves and four swirls");
        end
    end

    // Whole module state
    typedef struct packed {
        daio_pkg::daio_pins_type               pin_meta;
        daio_pkg::daio_pins_type               pin_sync;
        logic                                  strobe_prev;
        logic                                  done_prev;
        logic                                  fault_prev;
        logic                                  remote_prev;
        daio_pkg::daio_seq_type                seq;
        logic [15:0]                           purge_cnt;
        logic                                  ready;
        logic                                  job_active;
        logic [7:0]                            job_style;
        logic [7:0]                            error_num;
        logic                                  error_reset;
        logic [3:0]                            valve_open;
        logic [3:0]                            prech_en;
        logic [3:0]                            swirl_run;
        logic [15:0]                           cmd_scaled;
        logic [15:0]                           swirl_rpm;
        logic [daio_pkg::DAIO_CTRL_WIDTH-1:0]  ctrl;
        logic [15:0]                           flow_scale;
        logic [15:0]                           purge_len;
        logic [daio_pkg::DAIO_EV_WIDTH-1:0]    int_stat;
        logic [daio_pkg::DAIO_EV_WIDTH-1:0]    int_mask;
        logic                                  aw_held;
        logic [7:0]                            awaddr;
        logic                                  w_held;
        logic [31:0]                           wdata;
        logic [3:0]                            wstrb;
        logic                                  bvalid;
        logic [1:0]                            bresp;
        logic                                  rvalid;
        logic [31:0]                           rdata;
        logic [1:0]                            rresp;
    } daio_state_type;

    daio_state_type st_reg;
    daio_state_type st_next;

    // Merge write bytes under the strobes
    function automatic logic [31:0] daio_merge(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic                                  strobe_rise;
        logic                                  done_rise;
        logic                                  fault_rise;
        logic                                  remote_rise;
        logic [daio_pkg::DAIO_EV_WIDTH-1:0]    ev;
        logic [27:0]                           cmd_prod;
        logic [31:0]                           swirl_prod;
        logic [31:0]                           wr_word;
        logic                                  do_write;
        logic                                  wr_hit;
        logic [31:0]                           rd_word;
        logic                                  rd_hit;

        st_next     = st_reg;
        ev          = '0;
        wr_word     = 32'h0000_0000;
        wr_hit      = 1'b0;
        rd_word     = 32'h0000_0000;
        rd_hit      = 1'b1;

        // Two-stage synchronisers; stage one feeds only stage two
        st_next.pin_meta = PINS;
        st_next.pin_sync = st_reg.pin_meta;
        st_next.strobe_prev = st_reg.pin_sync.strobe;
        st_next.done_prev   = st_reg.pin_sync.done;
        st_next.fault_prev  = st_reg.pin_sync.fault_clr;
        st_next.remote_prev = st_reg.pin_sync.remote;

        // Edges: synchronised sample against the previous one
        strobe_rise = st_reg.pin_sync.strobe & ~st_reg.strobe_prev;
        done_rise   = st_reg.pin_sync.done & ~st_reg.done_prev;
        fault_rise  = st_reg.pin_sync.fault_clr & ~st_reg.fault_prev;
        remote_rise = st_reg.pin_sync.remote & ~st_reg.remote_prev;

        // Readiness ignores deviations: only activity and alarm count
        st_next.ready = SYS_ACTIVE & ~PLATE_ALARM;

        // Job tracking; a start in the same cycle as an end wins
        st_next.error_reset = 1'b0;
        if (st_reg.job_active && done_rise) begin
            st_next.job_active = 1'b0;
            ev[daio_pkg::DAIO_EV_JOB_END] = 1'b1;
        end
        if (fault_rise) begin
            if (st_reg.ctrl[daio_pkg::DAIO_CTRL_EOJF] && st_reg.job_active) begin
                st_next.job_active = 1'b0;
                ev[daio_pkg::DAIO_EV_JOB_CANCEL] = 1'b1;
            end else begin
                st_next.error_num   = 8'h00;
                st_next.error_reset = 1'b1;
                ev[daio_pkg::DAIO_EV_ERR_RESET] = 1'b1;
            end
        end
        if (strobe_rise) begin
            st_next.job_active = 1'b1;
            st_next.job_style  = st_reg.pin_sync.style;
            ev[daio_pkg::DAIO_EV_JOB_START] = 1'b1;
        end

        // Restart / purge sequencer drives the busy flag
        case (st_reg.seq)
            daio_pkg::DAIO_SEQ_IDLE: begin
                if (remote_rise) begin
                    if (st_reg.ready) begin
                        st_next.seq       = daio_pkg::DAIO_SEQ_PURGE;
                        st_next.purge_cnt = st_reg.purge_len;
                    end else begin
                        st_next.seq = daio_pkg::DAIO_SEQ_RESTART;
                    end
                end
            end
            daio_pkg::DAIO_SEQ_RESTART: begin
                if (st_reg.ready) begin
                    st_next.seq = daio_pkg::DAIO_SEQ_IDLE;
                    ev[daio_pkg::DAIO_EV_RESTART_OK] = 1'b1;
                end
            end
            daio_pkg::DAIO_SEQ_PURGE: begin
                if (st_reg.purge_cnt == 16'h0000) begin
                    st_next.seq = daio_pkg::DAIO_SEQ_IDLE;
                    ev[daio_pkg::DAIO_EV_PURGE_DONE] = 1'b1;
                end else begin
                    st_next.purge_cnt = st_reg.purge_cnt - 16'h0001;
                end
            end
            default: begin
                st_next.seq = daio_pkg::DAIO_SEQ_IDLE;
            end
        endcase

        // Actuators follow their bits; precharge only in gateway mode
        st_next.valve_open = st_reg.pin_sync.valve;
        st_next.swirl_run  = st_reg.pin_sync.swirl_en;
        st_next.prech_en   = st_reg.ctrl[daio_pkg::DAIO_CTRL_PRECH_GW] ?
                             st_reg.pin_sync.prech : 4'h0;

        // Command scale: 4.12 fixed-point factor
        cmd_prod = 28'(st_reg.pin_sync.cmd) * 28'(st_reg.flow_scale);
        st_next.cmd_scaled = cmd_prod[27:12];

        // Swirl speed: linear between end points
        swirl_prod = 32'(st_reg.pin_sync.swirl_cmd) * 32'(daio_pkg::DAIO_SWIRL_SPAN);
        st_next.swirl_rpm = daio_pkg::DAIO_SWIRL_MIN_RPM +
                            16'(swirl_prod / 32'(daio_pkg::DAIO_CODE_MAX));

        ////////////////////////////////////////////////////////////////////////
        // AXI write: address and data taken in either order, then one response
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            st_next.aw_held = 1'b1;
            st_next.awaddr  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            st_next.w_held = 1'b1;
            st_next.wdata  = S_AXI_WDATA;
            st_next.wstrb  = S_AXI_WSTRB;
        end
        do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
        if (do_write) begin
            wr_hit = 1'b1;
            case (st_reg.awaddr)
                daio_pkg::DAIO_REG_CTRL: begin
                    wr_word = daio_merge(32'(st_reg.ctrl), st_reg.wdata, st_reg.wstrb);
                    st_next.ctrl = wr_word[daio_pkg::DAIO_CTRL_WIDTH-1:0];
                end
                daio_pkg::DAIO_REG_INT_STAT: begin
                    // Write one to clear; events of this cycle are added below
                    wr_word = daio_merge(32'h0000_0000, st_reg.wdata, st_reg.wstrb);
                    st_next.int_stat = st_reg.int_stat &
                                       ~wr_word[daio_pkg::DAIO_EV_WIDTH-1:0];
                end
                daio_pkg::DAIO_REG_INT_MASK: begin
                    wr_word = daio_merge(32'(st_reg.int_mask), st_reg.wdata, st_reg.wstrb);
                    st_next.int_mask = wr_word[daio_pkg::DAIO_EV_WIDTH-1:0];
                end
                daio_pkg::DAIO_REG_ERROR: begin
                    // A fault reset in the same cycle wins
                    wr_word = daio_merge(32'(st_reg.error_num), st_reg.wdata, st_reg.wstrb);
                    if (!st_next.error_reset) begin
                        st_next.error_num = wr_word[7:0];
                    end
                end
                daio_pkg::DAIO_REG_FLOW_SCALE: begin
                    wr_word = daio_merge(32'(st_reg.flow_scale), st_reg.wdata, st_reg.wstrb);
                    st_next.flow_scale = wr_word[15:0];
                end
                daio_pkg::DAIO_REG_PURGE_LEN: begin
                    wr_word = daio_merge(32'(st_reg.purge_len), st_reg.wdata, st_reg.wstrb);
                    st_next.purge_len = wr_word[15:0];
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = wr_hit ? daio_pkg::DAIO_RESP_OKAY : daio_pkg::DAIO_RESP_SLVERR;
        end
        if (st_reg.bvalid && S_AXI_BREADY) begin
            st_next.bvalid = 1'b0;
        end

        // Sticky status: a new event wins over a clear in the same cycle
        st_next.int_stat = st_next.int_stat | ev;

        ////////////////////////////////////////////////////////////////////////
        // AXI read: one cycle from address to data
        case (S_AXI_ARADDR)
            daio_pkg::DAIO_REG_CTRL:       rd_word = 32'(st_reg.ctrl);
            daio_pkg::DAIO_REG_STATUS:     rd_word = {26'h0, st_reg.job_active,
                                                      st_reg.ready, st_reg.seq, 
                                                      st_reg.job_active & st_reg.ready};
            daio_pkg::DAIO_REG_INT_STAT:   rd_word = 32'(st_reg.int_stat);
            daio_pkg::DAIO_REG_INT_MASK:   rd_word = 32'(st_reg.int_mask);
            daio_pkg::DAIO_REG_ERROR:      rd_word = 32'(st_reg.error_num);
            daio_pkg::DAIO_REG_FLOW_SCALE: rd_word = 32'(st_reg.flow_scale);
            daio_pkg::DAIO_REG_PURGE_LEN:  rd_word = 32'(st_reg.purge_len);
            daio_pkg::DAIO_REG_JOB_STYLE:  rd_word = 32'(st_reg.job_style);
            daio_pkg::DAIO_REG_CMD_SCALED: rd_word = 32'(st_reg.cmd_scaled);
            daio_pkg::DAIO_REG_SWIRL_RPM:  rd_word = 32'(st_reg.swirl_rpm);
            default:                       rd_hit  = 1'b0;
        endcase
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_word;
            st_next.rresp  = rd_hit ? daio_pkg::DAIO_RESP_OKAY : daio_pkg::DAIO_RESP_SLVERR;
        end else if (st_reg.rvalid && S_AXI_RREADY) begin
            st_next.rvalid = 1'b0;
        end

        // Reserved mode and unit codes fall back to zero
        if (st_next.ctrl[daio_pkg::DAIO_CTRL_VMODE_LO +: 2] == 2'h3) begin
            st_next.ctrl[daio_pkg::DAIO_CTRL_VMODE_LO +: 2] = daio_pkg::DAIO_VMODE_PRES;
        end
        if (st_next.ctrl[daio_pkg::DAIO_CTRL_UNITS_LO +: 2] == 2'h3) begin
            st_next.ctrl[daio_pkg::DAIO_CTRL_UNITS_LO +: 2] = daio_pkg::DAIO_UNITS_PSI;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; synchronous reset to constants only
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_reg            <= '0;
            st_reg.seq        <= daio_pkg::DAIO_SEQ_IDLE;
            st_reg.flow_scale <= daio_pkg::DAIO_FLOW_SCALE_RST;
            st_reg.purge_len  <= daio_pkg::DAIO_PURGE_LEN_RST;
            st_reg.swirl_rpm  <= daio_pkg::DAIO_SWIRL_MIN_RPM;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from the state register
    assign START_PURGE_BUSY = (st_reg.seq != daio_pkg::DAIO_SEQ_IDLE);
    assign PRESSURE_UNITS   = st_reg.ctrl[daio_pkg::DAIO_CTRL_UNITS_LO +: 2];
    assign ERROR_NUM        = st_reg.error_num;
    assign VALVE_OPEN       = st_reg.valve_open;
    assign PRECHARGE_EN     = st_reg.prech_en;
    assign SWIRL_RUN        = st_reg.swirl_run;
    assign CMD_SCALED       = st_reg.cmd_scaled;
    assign CMD_IS_FLOW      = (st_reg.ctrl[daio_pkg::DAIO_CTRL_VMODE_LO +: 2] ==
                               daio_pkg::DAIO_VMODE_BEAD);
    assign SWIRL_RPM        = st_reg.swirl_rpm;
    assign JOB_ACTIVE       = st_reg.job_active;
    assign JOB_STYLE        = st_reg.job_style;
    assign DISPENSE_READY   = st_reg.ready;
    assign RESTART_REQ      = (st_reg.seq == daio_pkg::DAIO_SEQ_RESTART);
    assign PURGE_RUN        = (st_reg.seq == daio_pkg::DAIO_SEQ_PURGE);
    assign ERROR_RESET      = st_reg.error_reset;
    assign IRQ              = |(st_reg.int_stat & st_reg.int_mask);

    // Bus handshakes
    assign S_AXI_AWREADY = !st_reg.aw_held && !st_reg.bvalid;
    assign S_AXI_WREADY  = !st_reg.w_held && !st_reg.bvalid;
    assign S_AXI_BVALID  = st_reg.bvalid;
    assign S_AXI_BRESP   = st_reg.bresp;
    assign S_AXI_ARREADY = !st_reg.rvalid;
    assign S_AXI_RVALID  = st_reg.rvalid;
    assign S_AXI_RDATA   = st_reg.rdata;
    assign S_AXI_RRESP   = st_reg.rresp;

endmodule // daio_top

// *** src/daio_pkg.sv ***
// Package for the dispense automation interface: constants and types.
// Assumes a single 25 MHz system clock and a 32-bit AXI4-Lite register bus.
package daio_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] DAIO_REG_CTRL       = 8'h00;
    localparam logic [7:0] DAIO_REG_STATUS     = 8'h04;
    localparam logic [7:0] DAIO_REG_INT_STAT   = 8'h08;
    localparam logic [7:0] DAIO_REG_INT_MASK   = 8'h0C;
    localparam logic [7:0] DAIO_REG_ERROR      = 8'h10;
    localparam logic [7:0] DAIO_REG_FLOW_SCALE = 8'h14;
    localparam logic [7:0] DAIO_REG_PURGE_LEN  = 8'h18;
    localparam logic [7:0] DAIO_REG_JOB_STYLE  = 8'h1C;
    localparam logic [7:0] DAIO_REG_CMD_SCALED = 8'h20;
    localparam logic [7:0] DAIO_REG_SWIRL_RPM  = 8'h24;

    // Control register fields
    localparam int DAIO_CTRL_EOJF      = 0;
    localparam int DAIO_CTRL_UNITS_LO  = 1;
    localparam int DAIO_CTRL_PRECH_GW  = 3;
    localparam int DAIO_CTRL_VMODE_LO  = 4;
    localparam int DAIO_CTRL_WIDTH     = 6;

    // Interrupt event bit positions
    localparam int DAIO_EV_JOB_START   = 0;
    localparam int DAIO_EV_JOB_END     = 1;
    localparam int DAIO_EV_JOB_CANCEL  = 2;
    localparam int DAIO_EV_ERR_RESET   = 3;
    localparam int DAIO_EV_RESTART_OK  = 4;
    localparam int DAIO_EV_PURGE_DONE  = 5;
    localparam int DAIO_EV_WIDTH       = 6;

    // Reset values of writable registers
    localparam logic [15:0] DAIO_FLOW_SCALE_RST = 16'h1000;
    localparam logic [15:0] DAIO_PURGE_LEN_RST  = 16'h0100;

    // Pressure unit codes and valve modes
    localparam logic [1:0] DAIO_UNITS_PSI  = 2'h0;
    localparam logic [1:0] DAIO_UNITS_BAR  = 2'h1;
    localparam logic [1:0] DAIO_UNITS_MPA  = 2'h2;
    localparam logic [1:0] DAIO_VMODE_PRES = 2'h0;
    localparam logic [1:0] DAIO_VMODE_BEAD = 2'h1;
    localparam logic [1:0] DAIO_VMODE_SHOT = 2'h2;

    // Swirl speed end points
    localparam logic [15:0] DAIO_SWIRL_MIN_RPM = 16'd6600;
    localparam logic [15:0] DAIO_SWIRL_MAX_RPM = 16'd24000;
    localparam logic [15:0] DAIO_SWIRL_SPAN    = DAIO_SWIRL_MAX_RPM - DAIO_SWIRL_MIN_RPM;
    localparam logic [15:0] DAIO_CODE_MAX      = 16'h0FFF;

    // AXI responses
    localparam logic [1:0] DAIO_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DAIO_RESP_SLVERR = 2'h2;

    // Restart / purge sequencer, one-hot
    typedef enum logic [2:0] {
        DAIO_SEQ_IDLE    = 3'b001,
        DAIO_SEQ_RESTART = 3'b010,
        DAIO_SEQ_PURGE   = 3'b100
    } daio_seq_type;

    // Controller-driven pins, as one bundle
    typedef struct packed {
        logic [7:0]  style;
        logic        strobe;
        logic        done;
        logic [3:0]  valve;
        logic [3:0]  prech;
        logic [11:0] cmd;
        logic        fault_clr;
        logic        remote;
        logic [3:0]  swirl_en;
        logic [11:0] swirl_cmd;
    } daio_pins_type;

endpackage

// *** bench/daio_top_properties.sv ***
// Checker for daio_top job, sequence and follower timing.
// Sees only top-level ports; bound to daio_top.
`timescale 1ns/10ps
module daio_top_properties (
    // Clock, reset, inputs
    input wire logic CLK, SRST, SYS_ACTIVE, PLATE_ALARM,
    input wire daio_pkg::daio_pins_type PINS,
    // Outputs
    input wire logic [1:0] PRESSURE_UNITS,
    input wire logic [7:0] JOB_STYLE,
    input wire logic [3:0] VALVE_OPEN,
    input wire logic START_PURGE_BUSY, JOB_ACTIVE, DISPENSE_READY,
    input wire logic RESTART_REQ, PURGE_RUN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    ////////////////////////////////////////////////////////////////////////////
    // Follower window assumes pins hold six cycles
    a_reset_idle: assert property (disable iff (1'b0)
        $fell(SRST) |-> !START_PURGE_BUSY && !JOB_ACTIVE) else $error("flag set after reset");
    a_units_legal: assert property (PRESSURE_UNITS != 2'h3)
        else $error("reserved unit code");
    a_valve_follow: assert property (!$past(SRST, 5) &&
        $past(PINS.valve, 2) == $past(PINS.valve, 5) |-> VALVE_OPEN == $past(PINS.valve, 3))
        else $error("valve output lags pin");
    a_ready_def: assert property (!$past(SRST) |->
        DISPENSE_READY == $past(SYS_ACTIVE && !PLATE_ALARM)) else $error("ready wrong");
    a_job_start: assert property ($rose(PINS.strobe) |->
        ##[1:5] JOB_ACTIVE && JOB_STYLE == PINS.style) else $error("job not started");
    a_job_end: assert property ($rose(PINS.done) && JOB_ACTIVE |-> ##[1:5] !JOB_ACTIVE)
        else $error("job not ended");
    a_restart_hold: assert property (RESTART_REQ && !DISPENSE_READY |=> START_PURGE_BUSY)
        else $error("busy dropped before ready");
    a_purge_ready: assert property ($rose(PURGE_RUN) |-> $past(DISPENSE_READY) &&
        START_PURGE_BUSY) else $error("purge without ready");
    c_job: cover property ($rose(JOB_ACTIVE));
    c_restart: cover property ($fell(RESTART_REQ));
    c_purge: cover property ($fell(PURGE_RUN));
endmodule // daio_top_properties
bind daio_top daio_top_properties daio_top_properties_i (.*);

// *** bench/daio_ctrl_model.sv ***
// Automation controller model: drives the discrete job pins.
// Assumes PINS are sampled on rising CLK.
`timescale 1ns/10ps
module daio_ctrl_model (
    // Clock and pins
    input  wire logic               CLK,
    output daio_pkg::daio_pins_type PINS
);
    initial PINS = '0;
    // Each level stands six cycles so the synchroniser never misses it
    task automatic put(input daio_pkg::daio_pins_type v);
        @(posedge CLK);
        PINS <= v;
        repeat (6) @(posedge CLK);
    endtask
    // One pin to a level; edges come from here
    task automatic set(input int b, input logic l);
        daio_pkg::daio_pins_type v;
        v = PINS;
        v[b] = l;
        put(v);
    endtask
    // Style settles with the strobe low, then the strobe rises
    task automatic start(input logic [7:0] s);
        daio_pkg::daio_pins_type v;
        v = PINS;
        v.style = s;
        v.strobe = 1'b0;
        put(v);
        set(39, 1'b1);
    endtask
endmodule // daio_ctrl_model

// *** bench/daio_top_bench.sv ***
// Bench for daio_top: registers, jobs, fault clear, restart and purge.
// Assumes the controller model drives PINS and the checker is bound.
`timescale 1ns/10ps
module daio_top_bench;
    logic CLK = 0, SRST = 1, SYS_ACTIVE = 1, PLATE_ALARM = 0;
    logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
    logic S_AXI_RREADY = 0, START_PURGE_BUSY, CMD_IS_FLOW, JOB_ACTIVE, DISPENSE_READY;
    logic RESTART_REQ, PURGE_RUN, ERROR_RESET, IRQ, S_AXI_AWREADY, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] PRESSURE_UNITS, S_AXI_BRESP, S_AXI_RRESP;
    logic [3:0] VALVE_OPEN, PRECHARGE_EN, SWIRL_RUN, S_AXI_WSTRB = 4'hF;
    logic [7:0] ERROR_NUM, JOB_STYLE, S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic [15:0] CMD_SCALED, SWIRL_RPM;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
    daio_pkg::daio_pins_type PINS;
    int n_mismatch = 0;
    int checked = 0;
    localparam int B_DONE = 38, B_FCLR = 17, B_REM = 16;
    daio_top daio_top_i (.*);
    daio_ctrl_model m (.CLK(CLK), .PINS(PINS));
    ////////////////////////////////////////////////////////////////////////////
    initial forever #20 CLK = ~CLK;
    // Watchdog: the run needs well under 5000 cycles
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    task automatic chk(input logic [34:0] g, input logic [34:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    // AXI write: address and data offered together, bready held up
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge CLK);
        {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        do begin
            @(posedge CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
        chk({S_AXI_BVALID, S_AXI_BRESP}, {1'b1, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        do begin
            @(posedge CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
        chk({S_AXI_RVALID, S_AXI_RRESP, S_AXI_RDATA}, {1'b1, r, d});
    endtask
    // Reset values, unmapped and read-only places, unit codes
    task automatic t_regs();
        rd(daio_pkg::DAIO_REG_FLOW_SCALE, 32'h1000, 2'h0);
        rd(8'hFC, 32'h0, 2'h2);
        wr(daio_pkg::DAIO_REG_JOB_STYLE, 32'h1, 2'h2);
        for (int u = 0; u < 3; u++) begin
            wr(daio_pkg::DAIO_REG_CTRL, 32'(u * 2 + 'h18), 2'h0);
            chk({CMD_IS_FLOW, PRESSURE_UNITS}, 32'(u + 4));
        end
    endtask
    // Followers, job start and end, interrupt set, mask and clear
    task automatic t_job();
        wr(daio_pkg::DAIO_REG_INT_MASK, 32'h1, 2'h0);
        m.put('{valve: 4'h9, prech: 4'h5, swirl_en: 4'h6, cmd: 12'hFFF,
                swirl_cmd: 12'hFFF, default: '0});
        chk({VALVE_OPEN, SWIRL_RUN, PRECHARGE_EN}, 32'h965);
        chk({CMD_SCALED, SWIRL_RPM}, {16'h0FFF, 16'h5DC0});
        m.start(8'hA5);
        chk({JOB_ACTIVE, IRQ, JOB_STYLE}, 32'h3A5);
        wr(daio_pkg::DAIO_REG_INT_STAT, 32'h1, 2'h0);
        chk(IRQ, 32'h0);
        m.set(B_DONE, 1'b1);
        chk({JOB_ACTIVE, IRQ}, 32'h0);
        m.set(B_DONE, 1'b0);
    endtask
    // Fault clear cancels with end-job-on-fault, else clears errors
    task automatic t_fault();
        wr(daio_pkg::DAIO_REG_CTRL, 32'h1, 2'h0);
        m.start(8'h3C);
        m.set(B_FCLR, 1'b1);
        chk(JOB_ACTIVE, 32'h0);
        m.set(B_FCLR, 1'b0);
        wr(daio_pkg::DAIO_REG_CTRL, 32'h0, 2'h0);
        wr(daio_pkg::DAIO_REG_ERROR, 32'h5A, 2'h0);
        m.start(8'h11);
        m.set(B_FCLR, 1'b1);
        chk({JOB_ACTIVE, ERROR_NUM}, 32'h100);
        m.set(B_FCLR, 1'b0);
    endtask
    // Restart while alarmed, then purge once ready
    task automatic t_remote();
        PLATE_ALARM <= 1'b1;
        m.set(B_REM, 1'b1);
        chk({RESTART_REQ, START_PURGE_BUSY}, 32'h3);
        m.set(B_REM, 1'b0);
        chk(START_PURGE_BUSY, 32'h1);
        PLATE_ALARM <= 1'b0;
        repeat (3) @(posedge CLK);
        chk(START_PURGE_BUSY, 32'h0);
        wr(daio_pkg::DAIO_REG_PURGE_LEN, 32'h4, 2'h0);
        m.set(B_REM, 1'b1);
        chk({PURGE_RUN, START_PURGE_BUSY}, 32'h3);
        m.set(B_REM, 1'b0);
        chk({PURGE_RUN, START_PURGE_BUSY}, 32'h0);
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        t_regs();
        t_job();
        t_fault();
        t_remote();
        summarize();
    end
endmodule // daio_top_bench
